// >>> hdl/cpsc_pkg.sv
/*
 * Package of the processing-state controller: state, instruction and
 * exception encodings, access state counts and reset values.
 * Assumes one system clock; every count is in states of that clock.
 */
package cpsc_pkg;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET  = 4'h0,
      ST_RVEC   = 4'h1,
      ST_RUN    = 4'h2,
      ST_PUSHPC = 4'h3,
      ST_PUSHCC = 4'h4,
      ST_VEC    = 4'h5,
      ST_BUSREL = 4'h6,
      ST_SLEEP  = 4'h7,
      ST_SWSTBY = 4'h8,
      ST_HWSTBY = 4'h9
   } cpsc_state_t;

   typedef enum logic [1:0] {
      IK_PLAIN = 2'h0,
      IK_FLAGS = 2'h1,
      IK_TRAP  = 2'h2,
      IK_SLEEP = 2'h3
   } cpsc_ikind_t;

   typedef enum logic [1:0] {
      SP_MEM    = 2'h0,
      SP_PERIPH = 2'h1,
      SP_EXT    = 2'h2
   } cpsc_space_t;

   typedef enum logic [1:0] {
      EK_RESET = 2'h0,
      EK_IRQ   = 2'h1,
      EK_TRAP  = 2'h2,
      EK_NONE  = 2'h3
   } cpsc_exc_t;

   // ---------------------------------------------------------------
   // Counts, offsets and reset values
   // ---------------------------------------------------------------
   localparam int          AREAS          = 8;
   localparam logic [1:0]  MEM_STATES     = 2'h2;
   localparam logic [1:0]  PERIPH_STATES  = 2'h3;
   localparam logic [1:0]  EXT_SHORT      = 2'h2;
   localparam logic [1:0]  EXT_LONG       = 2'h3;
   localparam logic [1:0]  EXC_STEP       = 2'h2;
   localparam logic [7:0]  WDT_RST_STATES = 8'h04;
   localparam logic [23:0] PUSH_PC_OFS    = 24'h000002;
   localparam logic [23:0] PUSH_CC_OFS    = 24'h000004;
   localparam logic        INIT_MASK      = 1'b1;
   localparam logic        INIT_UE        = 1'b1;
   localparam logic        INIT_SLEEP_DEPTH_SEL      = 1'b0;

endpackage

// >>> hdl/cpsc_ctrl.sv
/*
 * Processing-state controller: reset, exception sequencing, interrupt
 * masking, bus release, power-down modes and access state timing.
 * Assumes an instruction sequencer that pulses instr_done at each
 * instruction end, an interrupt controller holding requests until
 * acknowledged, and an outside datapath that performs the stack and
 * vector accesses this block announces.
 */
//
// Summary of operation
// - Reset beats interrupt; interrupt beats trap.
// - Reset pin low aborts and holds reset.
// - Reset pin rising starts reset vector fetch.
// - Reset sets interrupt mask; nmi_req is not masked.
// - No interrupt during or right after reset.
// - Interrupts sampled at instruction/sequence ends, and at any time in sleep or software standby.
// - No interrupt after flag instructions or reset.
// - Trap instruction starts trap handling unless an interrupt is taken.
// - Push program counter, then flags, on stack.
// - Then set mask; also user bit if disabled.
// - Then fetch handler vector and branch.
// - Bus released on request; interrupts held off.
// - Watchdog overflow enters reset like the pin.
// - Sleep instruction, select 0: sleep mode.
// - Select 1: standby, clocks off, peripherals reset.
// - Standby pin low: halt, clocks off, reset.
// - Every access lasts two or three states.
// - On-chip memory: two states, 16-bit path.
// - Peripheral registers: three states, 8/16-bit path.
// - Eight external areas, configured width and length.
// - User-bit enable resets to one.
`timescale 1ns/10ps

module cpsc_ctrl #(
   parameter logic [7:0] WDT_HOLD = cpsc_pkg::WDT_RST_STATES
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // Pins
   input  wire logic               hard_init_n,
   input  wire logic               hw_standby_n,
   input  wire logic               wdt_overflow,
   // System control
   input  wire logic               sys_ctrl_wr,
   input  wire logic               sleep_depth_sel_wdata,
   input  wire logic               ue_wdata,
   output logic                    sleep_depth_sel_r,
   output logic                    user_bit_enable_r,
   // Instruction sequencer
   input  wire logic               instr_done,
   input  cpsc_pkg::cpsc_ikind_t   instr_kind,
   input  wire logic [1:0]         flags_wdata,
   // Interrupt controller
   input  wire logic               irq_req,
   input  wire logic               nmi_req,
   output logic                    irq_ack_r,
   // Exception sequence
   input  wire logic [31:0]        stack_ptr_reg,
   output cpsc_pkg::cpsc_state_t   cpu_state_r,
   output cpsc_pkg::cpsc_exc_t     exc_kind_r,
   output logic                    push_wr_r,
   output logic                    push_cc_r,
   output logic [23:0]             push_addr_r,
   output logic                    vec_fetch_r,
   // Condition flags
   output logic                    int_mask_r,
   output logic                    user_or_mask_bit_r,
   // Power
   output logic                    cpu_halt_r,
   output logic                    clk_halt_r,
   output logic                    periph_rst_r,
   // Bus arbitration
   input  wire logic               bus_req,
   output logic                    bus_grant_r,
   // Access timing
   input  wire logic               acc_req,
   input  cpsc_pkg::cpsc_space_t   acc_space,
   input  wire logic [2:0]         acc_area,
   input  wire logic               acc_word,
   input  wire logic [7:0]         area_wide,
   input  wire logic [7:0]         area_long,
   input  wire logic               periph_wide,
   output logic                    acc_busy_r,
   output logic                    acc_done_r,
   output logic                    acc_wide_r,
   output logic                    acc_word_r
);
   import cpsc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   cpsc_state_t st_nxt;
   cpsc_exc_t   exc_nxt;
   logic [1:0]  step_r, step_nxt;
   logic [7:0]  hold_r, hold_nxt;
   logic        block_r, block_nxt;
   logic        mask_nxt, umask_nxt, ue_nxt, sleep_depth_sel_nxt, ack_nxt;
   logic        boundary, flag_bound, wanted, accept, step_last, in_step;

   always_comb begin
      in_step    = (cpu_state_r == ST_PUSHPC) || (cpu_state_r == ST_PUSHCC)
                   || (cpu_state_r == ST_VEC) || (cpu_state_r == ST_RVEC);
      step_last  = in_step && (step_r == EXC_STEP - 2'h1);
      // Sampled here at instruction end or sequence end; sleep and software standby sample at any time
      boundary   = ((cpu_state_r == ST_RUN) && instr_done)
                   || ((cpu_state_r == ST_VEC) && step_last);
      flag_bound = (cpu_state_r == ST_RUN) && instr_done && (instr_kind == IK_FLAGS);
      wanted     = nmi_req || (irq_req && !int_mask_r);
      // Held off after reset and after flag instructions
      accept     = boundary && wanted && !block_r && !flag_bound;
   end

   always_comb begin
      st_nxt    = cpu_state_r;
      exc_nxt   = exc_kind_r;
      step_nxt  = in_step ? step_r + 2'h1 : 2'h0;
      hold_nxt  = (hold_r != 8'h00) ? hold_r - 8'h01 : 8'h00;
      block_nxt = block_r;
      mask_nxt  = int_mask_r;
      umask_nxt = user_or_mask_bit_r;
      ue_nxt    = sys_ctrl_wr ? ue_wdata : user_bit_enable_r;
      sleep_depth_sel_nxt  = sys_ctrl_wr ? sleep_depth_sel_wdata : sleep_depth_sel_r;
      ack_nxt   = 1'b0;
      if (step_last)
         step_nxt = 2'h0;
      unique case (cpu_state_r)
         ST_RESET: begin
            // Leaves the cycle after the pin rises
            if (hard_init_n && (hold_r == 8'h00))
               st_nxt = ST_RVEC;
         end
         ST_RVEC: begin
            if (step_last) begin
               st_nxt    = ST_RUN;
               block_nxt = 1'b1;
            end
         end
         ST_RUN: begin
            if (instr_done) begin
               block_nxt = 1'b0;
               if (flag_bound) begin
                  mask_nxt  = flags_wdata[0];
                  umask_nxt = flags_wdata[1];
               end
               // Interrupt outranks a trap at the same boundary
               if (accept) begin
                  st_nxt  = ST_PUSHPC;
                  exc_nxt = EK_IRQ;
                  ack_nxt = 1'b1;
               end else if (instr_kind == IK_TRAP) begin
                  st_nxt  = ST_PUSHPC;
                  exc_nxt = EK_TRAP;
               end else if (instr_kind == IK_SLEEP) begin
                  st_nxt = sleep_depth_sel_r ? ST_SWSTBY : ST_SLEEP;
               end else if (bus_req) begin
                  st_nxt = ST_BUSREL;
               end
            end
         end
         ST_PUSHPC: begin
            if (step_last)
               st_nxt = ST_PUSHCC;
         end
         ST_PUSHCC: begin
            if (step_last) begin
               st_nxt   = ST_VEC;
               mask_nxt = 1'b1;
               if (!user_bit_enable_r)
                  umask_nxt = 1'b1;
            end
         end
         ST_VEC: begin
            if (step_last) begin
               // A pending nmi_req chains straight into a new sequence; irq_req is masked here
               if (accept) begin
                  st_nxt  = ST_PUSHPC;
                  exc_nxt = EK_IRQ;
                  ack_nxt = 1'b1;
               end else begin
                  st_nxt  = ST_RUN;
                  exc_nxt = EK_NONE;
               end
            end
         end
         ST_BUSREL: begin
            if (!bus_req)
               st_nxt = ST_RUN;
         end
         ST_SLEEP, ST_SWSTBY: begin
            if (wanted) begin
               st_nxt  = ST_PUSHPC;
               exc_nxt = EK_IRQ;
               ack_nxt = 1'b1;
            end
         end
         ST_HWSTBY: begin
            // Standby exit always passes through reset
            if (hw_standby_n)
               st_nxt = ST_RESET;
         end
         default: st_nxt = ST_RESET;
      endcase
      // Reset sources override everything but the standby pin
      if (!hard_init_n || wdt_overflow || (cpu_state_r == ST_RESET)) begin
         if (cpu_state_r != ST_RESET || !hard_init_n || hold_r != 8'h00 || wdt_overflow)
            st_nxt = ST_RESET;
      end
      if (wdt_overflow)
         hold_nxt = WDT_HOLD;
      if (!hw_standby_n)
         st_nxt = ST_HWSTBY;
      if (st_nxt == ST_RESET || st_nxt == ST_HWSTBY) begin
         mask_nxt  = INIT_MASK;
         ue_nxt    = INIT_UE;
         sleep_depth_sel_nxt  = INIT_SLEEP_DEPTH_SEL;
         exc_nxt   = EK_RESET;
         ack_nxt   = 1'b0;
         step_nxt  = 2'h0;
         block_nxt = 1'b1;
      end
      if (st_nxt == ST_RVEC)
         exc_nxt = EK_RESET;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_state_r        <= ST_RESET;
         exc_kind_r         <= EK_RESET;
         step_r             <= 2'h0;
         hold_r             <= 8'h00;
         block_r            <= 1'b1;
         int_mask_r         <= INIT_MASK;
         user_or_mask_bit_r <= 1'b0;
         user_bit_enable_r  <= INIT_UE;
         sleep_depth_sel_r  <= INIT_SLEEP_DEPTH_SEL;
         irq_ack_r          <= 1'b0;
      end else begin
         cpu_state_r        <= st_nxt;
         exc_kind_r         <= exc_nxt;
         step_r             <= step_nxt;
         hold_r             <= hold_nxt;
         block_r            <= block_nxt;
         int_mask_r         <= mask_nxt;
         user_or_mask_bit_r <= umask_nxt;
         user_bit_enable_r  <= ue_nxt;
         sleep_depth_sel_r  <= sleep_depth_sel_nxt;
         irq_ack_r          <= ack_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Registered strobes decoded from the next state
   // ---------------------------------------------------------------
   logic        push_nxt, pcc_nxt, vec_nxt, halt_nxt, clkh_nxt, prst_nxt, grant_nxt;
   logic [23:0] paddr_nxt;

   always_comb begin
      push_nxt  = (st_nxt == ST_PUSHPC) || (st_nxt == ST_PUSHCC);
      pcc_nxt   = (st_nxt == ST_PUSHCC);
      paddr_nxt = stack_ptr_reg[23:0] - (pcc_nxt ? PUSH_CC_OFS : PUSH_PC_OFS);
      vec_nxt   = (st_nxt == ST_VEC) || (st_nxt == ST_RVEC);
      halt_nxt  = (st_nxt == ST_RESET) || (st_nxt == ST_BUSREL) || (st_nxt == ST_SLEEP)
                  || (st_nxt == ST_SWSTBY) || (st_nxt == ST_HWSTBY);
      clkh_nxt  = (st_nxt == ST_SWSTBY) || (st_nxt == ST_HWSTBY);
      prst_nxt  = clkh_nxt || (st_nxt == ST_RESET);
      grant_nxt = (st_nxt == ST_BUSREL);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         push_wr_r    <= 1'b0;
         push_cc_r    <= 1'b0;
         push_addr_r  <= 24'h000000;
         vec_fetch_r  <= 1'b0;
         cpu_halt_r   <= 1'b1;
         clk_halt_r   <= 1'b0;
         periph_rst_r <= 1'b1;
         bus_grant_r  <= 1'b0;
      end else begin
         push_wr_r    <= push_nxt;
         push_cc_r    <= pcc_nxt;
         push_addr_r  <= paddr_nxt;
         vec_fetch_r  <= vec_nxt;
         cpu_halt_r   <= halt_nxt;
         clk_halt_r   <= clkh_nxt;
         periph_rst_r <= prst_nxt;
         bus_grant_r  <= grant_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Access state timer
   // ---------------------------------------------------------------
   logic [1:0] area_len [AREAS];
   logic [1:0] acc_cnt_r, cnt_nxt, len;
   logic       busy_nxt, done_nxt, wide_nxt, word_nxt, take;

   for (genvar i = 0; i < AREAS; i++) begin : g_area
      assign area_len[i] = area_long[i] ? EXT_LONG : EXT_SHORT;
   end

   always_comb begin
      take     = acc_req && !acc_busy_r && (cpu_state_r == ST_RUN);
      len      = MEM_STATES;
      wide_nxt = acc_wide_r;
      word_nxt = acc_word_r;
      unique case (acc_space)
         SP_MEM:    len = MEM_STATES;
         SP_PERIPH: len = PERIPH_STATES;
         SP_EXT:    len = area_len[acc_area];
         default:   len = MEM_STATES;
      endcase
      busy_nxt = acc_busy_r && (acc_cnt_r != 2'h0);
      cnt_nxt  = busy_nxt ? acc_cnt_r - 2'h1 : 2'h0;
      if (take) begin
         busy_nxt = 1'b1;
         cnt_nxt  = len - 2'h1;
         unique case (acc_space)
            SP_MEM:    wide_nxt = 1'b1;
            SP_PERIPH: wide_nxt = periph_wide;
            SP_EXT:    wide_nxt = area_wide[acc_area];
            default:   wide_nxt = 1'b1;
         endcase
         word_nxt = acc_word;
      end
      // A reset or hardware standby aborts the access in flight
      if (st_nxt == ST_RESET || st_nxt == ST_HWSTBY) begin
         busy_nxt = 1'b0;
         cnt_nxt  = 2'h0;
      end
      done_nxt = busy_nxt && (cnt_nxt == 2'h0);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_cnt_r  <= 2'h0;
         acc_busy_r <= 1'b0;
         acc_done_r <= 1'b0;
         acc_wide_r <= 1'b0;
         acc_word_r <= 1'b0;
      end else begin
         acc_cnt_r  <= cnt_nxt;
         acc_busy_r <= busy_nxt;
         acc_done_r <= done_nxt;
         acc_wide_r <= wide_nxt;
         acc_word_r <= word_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence run_end_s;
      (cpu_state_r == ST_RUN) && instr_done && hard_init_n && hw_standby_n && !wdt_overflow;
   endsequence
   sequence stack_s;
      push_wr_r && !push_cc_r ##2 push_wr_r && push_cc_r;
   endsequence

   rst_hold_a:  assert property (!hard_init_n && hw_standby_n
                                 |=> cpu_state_r == ST_RESET)
      else $error("reset pin low but not in reset");
   rst_exit_a:  assert property ((cpu_state_r == ST_RESET) && hard_init_n
                                 && hw_standby_n && !wdt_overflow && (hold_r == 8'h00)
                                 |=> cpu_state_r == ST_RVEC && vec_fetch_r)
      else $error("reset release did not start vector fetch");
   rst_mask_a:  assert property (cpu_state_r == ST_RESET
                                 |-> int_mask_r && user_bit_enable_r)
      else $error("mask or user enable wrong in reset");
   rst_quiet_a: assert property (block_r && (cpu_state_r == ST_RUN)
                                 |=> !irq_ack_r)
      else $error("interrupt taken right after reset");
   flag_blk_a:  assert property (run_end_s ##0 (instr_kind == IK_FLAGS)
                                 |=> !irq_ack_r)
      else $error("interrupt taken after flag instruction");
   ack_point_a: assert property (irq_ack_r |-> $past(instr_done)
                                 || $past(step_last) || $past(cpu_state_r == ST_SLEEP)
                                 || $past(cpu_state_r == ST_SWSTBY))
      else $error("interrupt taken off a boundary");
   trap_go_a:   assert property (run_end_s ##0 (instr_kind == IK_TRAP)
                                 && !accept
                                 |=> cpu_state_r == ST_PUSHPC && exc_kind_r == EK_TRAP)
      else $error("trap did not start handling");
   prio_a:      assert property (run_end_s ##0 (instr_kind == IK_TRAP)
                                 && accept |=> exc_kind_r == EK_IRQ && irq_ack_r)
      else $error("trap beat interrupt");
   stack_ord_a: assert property ($rose(push_wr_r) && hw_standby_n
                                 && hard_init_n |-> stack_s ##2 vec_fetch_r && int_mask_r
                                 && (user_bit_enable_r || user_or_mask_bit_r))
      else $error("stacking, masking or vector order wrong");
   bus_rel_a:   assert property (bus_grant_r |-> cpu_halt_r ##1 !irq_ack_r)
      else $error("interrupt taken during bus release");
   wdt_rst_a:   assert property (wdt_overflow && hw_standby_n
                                 |=> cpu_state_r == ST_RESET)
      else $error("watchdog overflow missed reset");
   sleep_a:     assert property (run_end_s ##0 (instr_kind == IK_SLEEP)
                                 && !accept |=> cpu_halt_r
                                 && (clk_halt_r == sleep_depth_sel_r)
                                 && (periph_rst_r == sleep_depth_sel_r))
      else $error("sleep entry wrong");
   hw_hw_standby_n_a:   assert property (!hw_standby_n
                                 |=> clk_halt_r && periph_rst_r && cpu_halt_r)
      else $error("standby pin not obeyed");
   acc_len_a:   assert property (take && (len == 2'h2) && hw_standby_n
                                 && hard_init_n && !wdt_overflow
                                 |=> acc_busy_r [*2] ##1 !acc_busy_r)
      else $error("two-state access length wrong");
   acc_long_a:  assert property (take && (len == 2'h3) && hw_standby_n
                                 && hard_init_n && !wdt_overflow
                                 |=> acc_busy_r [*2] ##0 !acc_done_r ##1 acc_done_r)
      else $error("three-state access length wrong");

endmodule

// >>> verif/cpsc_partner.sv
/* Partner model: interrupt sources and outside bus master.
   Assumes the device acknowledges one request at a time. */
`timescale 1ns/10ps
module cpsc_partner (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Bench commands
   input  wire logic raise_irq,
   input  wire logic raise_nmi,
   input  wire logic want_bus,
   // Device side
   input  wire logic irq_ack_r,
   output logic      irq_req,
   output logic      nmi_req,
   output logic      bus_req
);
   // ----------------------------------------
   // Interrupt requests held until acknowledged
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_req <= 1'h0;
         nmi_req <= 1'h0;
      end else if (irq_ack_r) begin
         irq_req <= 1'h0;
         nmi_req <= 1'h0;
      end else begin
         irq_req <= irq_req | raise_irq;
         nmi_req <= nmi_req | raise_nmi;
      end
   end
   assign bus_req = want_bus;
endmodule

// >>> verif/cpsc_ctrl_test.sv
/* Self-checking bench of the processing-state controller.
   Assumes the partner model drives the requests; inputs move 2 ns after edges. */
`timescale 1ns/10ps
module cpsc_ctrl_test;
   import cpsc_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_sys = 1'h0, rst_n = 1'h0, hard_init_n = 1'h1, hw_standby_n = 1'h1;
   logic wdt_overflow = 1'h0, sys_ctrl_wr = 1'h0, sleep_depth_sel_wdata = 1'h0, ue_wdata = 1'h1;
   logic instr_done = 1'h0, acc_req = 1'h0, acc_word = 1'h0, periph_wide = 1'h1;
   logic raise_irq = 1'h0, raise_nmi = 1'h0, want_bus = 1'h0;
   logic [1:0]  flags_wdata = 2'h0;
   logic [2:0]  acc_area = 3'h0;
   logic [7:0]  area_wide = 8'hA5, area_long = 8'h0F;
   logic [31:0] stack_ptr_reg = 32'h00001000;
   cpsc_ikind_t instr_kind = IK_PLAIN;
   cpsc_space_t acc_space = SP_MEM;
   logic sleep_depth_sel_r, user_bit_enable_r, irq_ack_r, push_wr_r, push_cc_r;
   logic vec_fetch_r, int_mask_r, user_or_mask_bit_r, cpu_halt_r, clk_halt_r;
   logic periph_rst_r, bus_grant_r, acc_busy_r, acc_done_r, acc_wide_r, acc_word_r;
   logic irq_req, nmi_req, bus_req;
   logic [23:0] push_addr_r;
   cpsc_state_t cpu_state_r;
   cpsc_exc_t   exc_kind_r;
   int          err_count = 0, n_tests = 0;

   always #12.5 clk_sys = ~clk_sys;

   cpsc_ctrl #(.WDT_HOLD(8'h02)) cpsc_ctrl_i (.clk_sys, .rst_n, .hard_init_n, .hw_standby_n,
      .wdt_overflow, .sys_ctrl_wr, .sleep_depth_sel_wdata, .ue_wdata, .sleep_depth_sel_r,
      .user_bit_enable_r, .instr_done, .instr_kind, .flags_wdata, .irq_req, .nmi_req,
      .irq_ack_r, .stack_ptr_reg, .cpu_state_r, .exc_kind_r, .push_wr_r, .push_cc_r,
      .push_addr_r, .vec_fetch_r, .int_mask_r, .user_or_mask_bit_r, .cpu_halt_r,
      .clk_halt_r, .periph_rst_r, .bus_req, .bus_grant_r, .acc_req, .acc_space, .acc_area,
      .acc_word, .area_wide, .area_long, .periph_wide, .acc_busy_r, .acc_done_r,
      .acc_wide_r, .acc_word_r);
   cpsc_partner cpsc_partner_i (.clk_sys, .rst_n, .raise_irq, .raise_nmi, .want_bus,
      .irq_ack_r, .irq_req, .nmi_req, .bus_req);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task step;
      @(posedge clk_sys);
      #2;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task instr(input cpsc_ikind_t k, input logic [1:0] f);
      instr_kind = k;
      flags_wdata = f;
      instr_done = 1'h1;
      step;
      instr_done = 1'h0;
   endtask
   task poke(input logic nmi);
      raise_nmi = nmi;
      raise_irq = ~nmi;
      step;
      raise_nmi = 1'h0;
      raise_irq = 1'h0;
   endtask
   task sysw(input logic s, input logic u);
      {sys_ctrl_wr, sleep_depth_sel_wdata, ue_wdata} = {1'h1, s, u};
      step;
      sys_ctrl_wr = 1'h0;
   endtask
   task wait_run;
      int c;
      c = 0;
      while (cpu_state_r !== ST_RUN && c < 20) begin
         step;
         c++;
      end
      chk(cpu_state_r, ST_RUN);
   endtask
   task acc(input cpsc_space_t s, input logic [2:0] a, input logic w);
      logic [1:0] n;
      logic       ew;
      int         c;
      n = (s == SP_MEM) ? MEM_STATES : (s == SP_PERIPH) ? PERIPH_STATES :
          (area_long[a] ? EXT_LONG : EXT_SHORT);
      ew = (s == SP_MEM) ? 1'h1 : (s == SP_PERIPH) ? periph_wide : area_wide[a];
      acc_space = s;
      acc_area = a;
      acc_word = w;
      acc_req = 1'h1;
      step;
      acc_req = 1'h0;
      c = 1;
      while (acc_done_r !== 1'h1 && c < 8) begin
         step;
         c++;
      end
      chk(c, n);
      chk({acc_busy_r, acc_wide_r, acc_word_r}, {1'h1, ew, w});
      step;
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      #(25 * 3000);
      err_count++;
      test_done;
   end
   initial begin
      repeat (4) step;
      rst_n = 1'h1;
      chk({user_bit_enable_r, int_mask_r}, 2'h3);
      wait_run;
      poke(1'h1);
      instr(IK_PLAIN, 2'h0);
      chk(irq_ack_r, 1'h0);
      step;
      instr(IK_PLAIN, 2'h0);
      chk(irq_ack_r, 1'h1);
      wait_run;
      $display("reset test done");
      sysw(1'h0, 1'h0);
      instr(IK_FLAGS, 2'h0);
      step;
      instr(IK_TRAP, 2'h0);
      chk({cpu_state_r, exc_kind_r, push_wr_r}, {ST_PUSHPC, EK_TRAP, 1'h1});
      chk(push_addr_r, stack_ptr_reg[23:0] - PUSH_PC_OFS);
      repeat (2) step;
      chk({push_cc_r, push_addr_r}, {1'h1, stack_ptr_reg[23:0] - PUSH_CC_OFS});
      repeat (2) step;
      chk({cpu_state_r, vec_fetch_r}, {ST_VEC, 1'h1});
      step;
      chk({user_or_mask_bit_r, int_mask_r}, 2'h3);
      wait_run;
      sysw(1'h0, 1'h1);
      poke(1'h0);
      instr(IK_FLAGS, 2'h0);
      chk(irq_ack_r, 1'h0);
      step;
      chk(irq_ack_r, 1'h0);
      instr(IK_TRAP, 2'h0);
      chk({irq_ack_r, exc_kind_r}, {1'h1, EK_IRQ});
      wait_run;
      chk({user_or_mask_bit_r, int_mask_r}, 2'h1);
      $display("exception test done");
      want_bus = 1'h1;
      instr(IK_PLAIN, 2'h0);
      step;
      chk({bus_grant_r, cpu_halt_r, cpu_state_r}, {2'h3, ST_BUSREL});
      poke(1'h1);
      repeat (3) step;
      chk(irq_ack_r, 1'h0);
      want_bus = 1'h0;
      repeat (2) step;
      chk(bus_grant_r, 1'h0);
      instr(IK_PLAIN, 2'h0);
      chk(irq_ack_r, 1'h1);
      step;
      poke(1'h1);
      repeat (4) step;
      chk({cpu_state_r, irq_ack_r}, {ST_PUSHPC, 1'h1});
      wait_run;
      $display("bus test done");
      instr(IK_SLEEP, 2'h0);
      chk({cpu_state_r, cpu_halt_r, clk_halt_r}, {ST_SLEEP, 2'h2});
      poke(1'h1);
      step;
      chk(cpu_state_r, ST_PUSHPC);
      wait_run;
      sysw(1'h1, 1'h1);
      chk(sleep_depth_sel_r, 1'h1);
      instr(IK_SLEEP, 2'h0);
      chk({cpu_state_r, clk_halt_r, periph_rst_r}, {ST_SWSTBY, 2'h3});
      hard_init_n = 1'h0;
      repeat (2) step;
      chk({cpu_state_r, int_mask_r}, {ST_RESET, 1'h1});
      hard_init_n = 1'h1;
      step;
      chk(cpu_state_r, ST_RVEC);
      wait_run;
      sysw(1'h0, 1'h1);
      hw_standby_n = 1'h0;
      repeat (2) step;
      chk({cpu_state_r, cpu_halt_r, clk_halt_r, periph_rst_r}, {ST_HWSTBY, 3'h7});
      hw_standby_n = 1'h1;
      wait_run;
      wdt_overflow = 1'h1;
      step;
      wdt_overflow = 1'h0;
      chk({cpu_state_r, periph_rst_r}, {ST_RESET, 1'h1});
      wait_run;
      $display("power test done");
      acc(SP_MEM, 3'h0, 1'h0);
      acc(SP_MEM, 3'h0, 1'h1);
      acc(SP_PERIPH, 3'h2, 1'h1);
      acc(SP_EXT, 3'h0, 1'h1);
      acc(SP_EXT, 3'h6, 1'h0);
      $display("access test done");
      test_done;
   end
endmodule
